// ===== core/ssf_map.svh
// Operation
// R01: First-scan flag one scan after power/program-to-run.
// R02: Always-on flag reads asserted every scan.
// R03: Always-off flag always reads deasserted.
// R04: Minute wave: 30 s high, 30 s low.
// R05: Second wave: 0.5 s high, 0.5 s low.
// R06: Tenth-second wave: 50 ms high, low.
// R07: Twentieth-second wave: 25 ms high, low.
// R08: Alternate-scan flag toggles at each scan boundary.
// R09: Switch-run flag: switch at run, CPU running.
// R10: Terminal-run flag: terminal position, CPU running.
// R11: Test-run flag follows test run mode.
// R12: Test-stop flag follows test stop mode.
// R13: Terminal-program flag: terminal position, program mode.
// R14: Switch-stop flag whenever switch at stop.
// R15: Instruction-stop flag when program executes stop.
// R16: Interrupt-enabled flag set by enable instruction.
// R17: Flags driven only by device, read-only.
// R18: Disable instruction and reset clear interrupt-enabled.
// R19: Square waves share one free-running time base.
`ifndef SSF_MAP_SVH
`define SSF_MAP_SVH

// Clock rate in hertz and the derived one-millisecond tick count.
`define SSF_CLK_HZ        20000000
`define SSF_MS_CYCLES     (`SSF_CLK_HZ / 1000)

// Half periods of the four square waves, in milliseconds.
`define SSF_HALF_MINUTE_MS 30000
`define SSF_HALF_SECOND_MS 500
`define SSF_HALF_TENTH_MS  50
`define SSF_HALF_TWENT_MS  25

// Wishbone register byte offsets.
`define SSF_REG_FLAGS     4'h0
`define SSF_REG_MODE      4'h4

// Bit positions inside the flags register.
`define SSF_B_FIRST       0
`define SSF_B_ON          1
`define SSF_B_OFF         2
`define SSF_B_MIN         3
`define SSF_B_SEC         4
`define SSF_B_TENTH       5
`define SSF_B_TWENT       6
`define SSF_B_ALT         7
`define SSF_B_SWRUN       8
`define SSF_B_TRUN        9
`define SSF_B_TSTRUN      10
`define SSF_B_TSTSTOP     11
`define SSF_B_TPGM        12
`define SSF_B_SWSTOP      13
`define SSF_B_ISTOP       14
`define SSF_B_INTEN       15

`endif

// ===== core/ssf_pkg.sv
package ssf_pkg;

  // Mode selector switch position.
  typedef enum logic [1:0] {
    SSF_SW_STOP = 2'b00,
    SSF_SW_RUN  = 2'b01,
    SSF_SW_TERM = 2'b10
  } ssf_switch_t;

  // CPU operating state.
  typedef enum logic [1:0] {
    SSF_CPU_PROGRAM   = 2'b00,
    SSF_CPU_RUN       = 2'b01,
    SSF_CPU_TEST_RUN  = 2'b10,
    SSF_CPU_TEST_STOP = 2'b11
  } ssf_cpu_t;

  // Bundle of all sixteen status flags.
  typedef struct packed {
    logic interrupt_enabled_flag;
    logic instruction_stop_flag;
    logic switch_stop_flag;
    logic terminal_program_flag;
    logic test_stop_flag;
    logic test_run_flag;
    logic terminal_run_flag;
    logic switch_run_flag;
    logic alternate_scan_flag;
    logic twentieth_second_square_wave;
    logic tenth_second_square_wave;
    logic second_square_wave;
    logic minute_square_wave;
    logic always_off_flag;
    logic always_on_flag;
    logic first_scan_flag;
  } ssf_flags_t;

  // Square-wave generator state.
  typedef struct packed {
    logic [15:0] ms_div;
    logic [15:0] cnt_min;
    logic [8:0]  cnt_sec;
    logic [5:0]  cnt_tenth;
    logic [4:0]  cnt_twent;
    logic [3:0]  waves;
  } ssf_tb_state_t;

endpackage

// ===== core/ssf_timebase.sv
`timescale 1ns/1ps
`include "ssf_map.svh"

// Free-running time base: one millisecond tick feeds four half-period
// counters, so all four waves keep a fixed phase to each other.
module ssf_timebase #(
  parameter int MS_CYCLES = `SSF_MS_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  output logic      [3:0] waves
);

  // The divider is sixteen bits wide, so longer ticks cannot be served.
  if (MS_CYCLES < 1 || MS_CYCLES > 65535) begin : g_bad_ms
    $error("ssf_timebase: MS_CYCLES out of range.");
  end

  ssf_pkg::ssf_tb_state_t st;       // Registered state.
  ssf_pkg::ssf_tb_state_t next_st;  // Next state.
  logic                   tick;     // One-millisecond enable.

  // Advance counters; each wave flips when its half period elapses.
  always_comb begin
    next_st = st;
    tick = (st.ms_div == 16'(MS_CYCLES - 1));
    next_st.ms_div = tick ? 16'h0000 : st.ms_div + 16'h0001;
    if (tick) begin // R19
      if (st.cnt_min == 16'(`SSF_HALF_MINUTE_MS - 1)) begin // R04
        next_st.cnt_min = 16'h0000;
        next_st.waves[3] = ~st.waves[3];
      end else begin
        next_st.cnt_min = st.cnt_min + 16'h0001;
      end
      if (st.cnt_sec == 9'(`SSF_HALF_SECOND_MS - 1)) begin // R05
        next_st.cnt_sec = 9'h000;
        next_st.waves[2] = ~st.waves[2];
      end else begin
        next_st.cnt_sec = st.cnt_sec + 9'h001;
      end
      if (st.cnt_tenth == 6'(`SSF_HALF_TENTH_MS - 1)) begin // R06
        next_st.cnt_tenth = 6'h00;
        next_st.waves[1] = ~st.waves[1];
      end else begin
        next_st.cnt_tenth = st.cnt_tenth + 6'h01;
      end
      if (st.cnt_twent == 5'(`SSF_HALF_TWENT_MS - 1)) begin // R07
        next_st.cnt_twent = 5'h00;
        next_st.waves[0] = ~st.waves[0];
      end else begin
        next_st.cnt_twent = st.cnt_twent + 5'h01;
      end
    end
  end

  // Waves start high after reset.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '{default: '0, waves: 4'hf};
    end else begin
      st <= next_st;
    end
  end

  assign waves = st.waves;

endmodule

// ===== core/ssf_top.sv
`timescale 1ns/1ps
`include "ssf_map.svh"

// Status flag generator with a read-only classic Wishbone slave.
module ssf_top #(
  parameter int MS_CYCLES = `SSF_MS_CYCLES
) (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic                 scan_boundary,
  input  wire ssf_pkg::ssf_switch_t mode_switch,
  input  wire ssf_pkg::ssf_cpu_t    cpu_state,
  input  wire logic                 stop_instruction,
  input  wire logic                 interrupt_enable_instruction,
  input  wire logic                 interrupt_disable_instruction,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  input  wire logic [3:0]           wb_sel_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  output logic                      wb_err_o,
  output ssf_pkg::ssf_flags_t       flags
);

  // Whole state of this module.
  typedef struct packed {
    ssf_pkg::ssf_flags_t flags;
    logic                first_pending;
    ssf_pkg::ssf_cpu_t   cpu_prev;       // CPU state of the previous cycle.
    logic [31:0]         dat;
    logic                ack;
    logic                err;
  } ssf_top_state_t;

  ssf_top_state_t   st;
  ssf_top_state_t   next_st;
  logic      [3:0]  waves;
  logic             run_now;
  logic             entering_run;

  // Shared time base for the four square waves.
  ssf_timebase #(
    .MS_CYCLES (MS_CYCLES)
  ) u_tb (
    .clk    (clk),
    .resetn (resetn),
    .waves  (waves)
  );

  // Returns true when the CPU is executing the program normally.
  function automatic logic is_running(input ssf_pkg::ssf_cpu_t c);
    return c == ssf_pkg::SSF_CPU_RUN;
  endfunction

  assign run_now      = is_running(cpu_state);
  // Run entry is seen only from program mode; test modes do not arm the flag.
  assign entering_run = run_now && (st.cpu_prev == ssf_pkg::SSF_CPU_PROGRAM);

  // Flag logic and Wishbone answer. Writes are acknowledged but ignored,
  // so software has no path to alter any flag.
  always_comb begin
    next_st = st;
    next_st.cpu_prev = cpu_state;
    // First scan: armed by reset or program-to-run; live for one scan.
    if (scan_boundary) begin
      // A run entry in the boundary cycle still marks the scan starting now.
      next_st.flags.first_scan_flag = st.first_pending || entering_run; // R01
      next_st.first_pending = 1'b0;
      next_st.flags.alternate_scan_flag = ~st.flags.alternate_scan_flag; // R08
    end else if (entering_run) begin // R01
      next_st.first_pending = 1'b1;
    end
    next_st.flags.always_on_flag = 1'b1; // R02
    next_st.flags.always_off_flag = 1'b0; // R03
    next_st.flags.minute_square_wave = waves[3]; // R04
    next_st.flags.second_square_wave = waves[2]; // R05
    next_st.flags.tenth_second_square_wave = waves[1]; // R06
    next_st.flags.twentieth_second_square_wave = waves[0]; // R07
    next_st.flags.switch_run_flag =
      (mode_switch == ssf_pkg::SSF_SW_RUN) && run_now; // R09
    next_st.flags.terminal_run_flag =
      (mode_switch == ssf_pkg::SSF_SW_TERM) && run_now; // R10
    next_st.flags.test_run_flag = (cpu_state == ssf_pkg::SSF_CPU_TEST_RUN); // R11
    next_st.flags.test_stop_flag = (cpu_state == ssf_pkg::SSF_CPU_TEST_STOP); // R12
    next_st.flags.terminal_program_flag = (mode_switch == ssf_pkg::SSF_SW_TERM)
      && (cpu_state == ssf_pkg::SSF_CPU_PROGRAM); // R13
    next_st.flags.switch_stop_flag = (mode_switch == ssf_pkg::SSF_SW_STOP); // R14
    // Instruction stop holds until the CPU next enters run from program mode.
    if (stop_instruction) begin
      next_st.flags.instruction_stop_flag = 1'b1; // R15
    end else if (entering_run) begin
      next_st.flags.instruction_stop_flag = 1'b0;
    end
    // Enable wins when both instructions coincide.
    if (interrupt_enable_instruction) begin
      next_st.flags.interrupt_enabled_flag = 1'b1; // R16
    end else if (interrupt_disable_instruction) begin
      next_st.flags.interrupt_enabled_flag = 1'b0; // R18
    end
    // One-wait-state slave; ack drops the cycle after it was given.
    next_st.ack = 1'b0;
    next_st.err = 1'b0;
    next_st.dat = 32'h00000000;
    if (wb_cyc_i && wb_stb_i && !st.ack && !st.err) begin
      if (wb_adr_i == `SSF_REG_FLAGS) begin
        next_st.ack = 1'b1;
        next_st.dat = {16'h0000, st.flags}; // R17
      end else if (wb_adr_i == `SSF_REG_MODE) begin
        next_st.ack = 1'b1;
        next_st.dat = {28'h0000000, cpu_state, mode_switch};
      end else begin
        next_st.err = 1'b1;
      end
    end
  end

  // Reset arms the first-scan flag for the first scan after power-up.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '{default: '0, first_pending: 1'b1, cpu_prev: ssf_pkg::SSF_CPU_PROGRAM};
    end else begin
      st <= next_st;
    end
  end

  assign flags    = st.flags;
  assign wb_dat_o = st.dat;
  assign wb_ack_o = st.ack;
  assign wb_err_o = st.err;

endmodule

// ===== testbench/ssf_top_chk.sv
`timescale 1ns/1ps

// Watches the flag outputs at the top ports; each check against an input looks one cycle back,
// because the flags are registered.
module ssf_top_chk #(
  parameter int MS_CYCLES = 20000
) (
  input wire logic                 clk,
  input wire logic                 resetn,
  input wire logic                 scan_boundary,
  input wire ssf_pkg::ssf_switch_t mode_switch,
  input wire ssf_pkg::ssf_cpu_t    cpu_state,
  input wire logic                 stop_instruction,
  input wire logic                 interrupt_enable_instruction,
  input wire logic                 interrupt_disable_instruction,
  input wire ssf_pkg::ssf_flags_t  flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Arming of the first-scan flag, as the ports show it.
  ssf_pkg::ssf_cpu_t cpu_q;    // CPU state of the previous cycle.
  logic              armed_q;  // A first scan is owed at the next boundary.
  logic              run_in;   // Program-to-run step in this cycle.

  assign run_in = (cpu_state == ssf_pkg::SSF_CPU_RUN) && (cpu_q == ssf_pkg::SSF_CPU_PROGRAM);

  // Reset and run entry arm the flag; a scan boundary consumes it.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpu_q <= ssf_pkg::SSF_CPU_PROGRAM;
      armed_q <= 1'b1;
    end else begin
      cpu_q <= cpu_state;
      if (scan_boundary) begin
        armed_q <= 1'b0;
      end else if (run_in) begin
        armed_q <= 1'b1;
      end
    end
  end

  a_off_low: assert property (!flags.always_off_flag)
    else $error("always off flag seen high");
  a_on_high: assert property ($past(resetn) |-> flags.always_on_flag)
    else $error("always on flag seen low");
  a_sw_run: assert property ($past(resetn) |-> flags.switch_run_flag ==
    ($past(mode_switch) == ssf_pkg::SSF_SW_RUN && $past(cpu_state) == ssf_pkg::SSF_CPU_RUN))
    else $error("switch run flag wrong");
  a_sw_stop: assert property ($past(resetn) |-> flags.switch_stop_flag ==
    ($past(mode_switch) == ssf_pkg::SSF_SW_STOP)) else $error("switch stop flag wrong");
  a_test_run: assert property ($past(resetn) |-> flags.test_run_flag ==
    ($past(cpu_state) == ssf_pkg::SSF_CPU_TEST_RUN)) else $error("test run flag wrong");
  a_alt_toggle: assert property ($past(resetn) && $past(scan_boundary) |->
    flags.alternate_scan_flag != $past(flags.alternate_scan_flag)) else $error("no toggle");
  a_first_ends: assert property ($past(resetn) && $past(scan_boundary) |->
    flags.first_scan_flag == ($past(armed_q) || $past(run_in)))
    else $error("first scan flag wrong");
  a_int_set: assert property ($past(resetn) && $past(interrupt_enable_instruction)
    |-> flags.interrupt_enabled_flag) else $error("interrupt enable not set");
  a_int_clear: assert property ($past(resetn) && $past(interrupt_disable_instruction)
    && !$past(interrupt_enable_instruction) |-> !flags.interrupt_enabled_flag)
    else $error("interrupt enable not cleared");
  // The slow wave may only move when the fast one moves: one shared time base.
  a_wave_phase: assert property ($changed(flags.tenth_second_square_wave)
    |-> $changed(flags.twentieth_second_square_wave)) else $error("wave phase slipped");
endmodule

bind ssf_top ssf_top_chk #(.MS_CYCLES(MS_CYCLES)) i_chk (
  .clk(clk), .resetn(resetn), .scan_boundary(scan_boundary), .mode_switch(mode_switch),
  .cpu_state(cpu_state), .stop_instruction(stop_instruction),
  .interrupt_enable_instruction(interrupt_enable_instruction),
  .interrupt_disable_instruction(interrupt_disable_instruction), .flags(flags));

// ===== testbench/ssf_plc_model.sv
`timescale 1ns/1ps

// Stands in for the mode switch and the user program.
// Pulse bits: 0 scan start, 1 stop, 2 interrupt enable, 3 interrupt disable.
module ssf_plc_model (
  input  wire logic           clk,
  output ssf_pkg::ssf_switch_t mode_switch,
  output ssf_pkg::ssf_cpu_t    cpu_state,
  output logic [3:0]           pulses
);
  // Power up in program mode so the first run entry is a real transition.
  initial begin
    mode_switch = ssf_pkg::SSF_SW_RUN;
    cpu_state = ssf_pkg::SSF_CPU_PROGRAM;
    pulses = 4'h0;
  end

  // One-cycle event, launched just after an edge.
  task automatic pulse(input int i);
    @(posedge clk);
    pulses[i] <= 1'b1;
    @(posedge clk);
    pulses[i] <= 1'b0;
  endtask

  task automatic set_mode(input ssf_pkg::ssf_switch_t s, input ssf_pkg::ssf_cpu_t c);
    @(posedge clk);
    mode_switch <= s;
    cpu_state <= c;
  endtask
endmodule

// ===== testbench/ssf_top_test.sv
`timescale 1ns/1ps
`include "ssf_map.svh"

`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end

module ssf_top_test;
  localparam int MS = 4;         // Short millisecond keeps the waves quick.
  logic                 clk;
  logic                 resetn;
  logic                 cyc;
  logic                 stb;
  logic                 we;
  logic [3:0]           adr;
  logic [31:0]          wdat;
  logic [3:0]           sel;
  logic [31:0]          rdat;
  logic                 ack;
  logic                 err;
  logic [31:0]          d;
  logic                 e;
  ssf_pkg::ssf_flags_t  flags;
  ssf_pkg::ssf_switch_t sw;
  ssf_pkg::ssf_cpu_t    cpu;
  logic [3:0]           pul;
  logic [5:0]           xm;         // Expected mode flags.
  logic [5:0]           gm;         // Seen mode flags.
  int                   error_cnt;
  int                   n_tests;
  int                   cycles = 0;

  ssf_plc_model i_prt (.clk(clk), .mode_switch(sw), .cpu_state(cpu), .pulses(pul));
  ssf_top #(.MS_CYCLES(MS)) i_dut (.clk(clk), .resetn(resetn), .scan_boundary(pul[0]),
    .mode_switch(sw), .cpu_state(cpu), .stop_instruction(pul[1]),
    .interrupt_enable_instruction(pul[2]), .interrupt_disable_instruction(pul[3]),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .flags(flags));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Classic cycle: hold the request until ack or err is sampled, then release.
  task automatic wb(input logic [3:0] a, input logic w);
    @(posedge clk);
    {cyc, stb, adr, we, wdat, sel} <= {2'h3, a, w, 32'hffff_ffff, 4'hf};
    do @(posedge clk); while (ack !== 1'b1 && err !== 1'b1);
    d = rdat;
    e = err;
    {cyc, stb} <= 2'h0;
  endtask

  // Measures one half period of a wave, in cycles, from edge to edge.
  task automatic half(input int b, input int n);
    logic v;
    int   c;
    v = flags[b];
    while (flags[b] === v) @(posedge clk);
    v = flags[b];
    c = 0;
    while (flags[b] === v) begin
      @(posedge clk);
      c++;
    end
    `CHK("half period", n, c)
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // A hang counts as a mismatch and ends the run.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    {resetn, cyc, stb, we} = 4'h0;
    adr = 4'h0;
    wdat = 32'h0000_0000;
    sel = 4'h0;
    error_cnt = 0;
    n_tests = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("always on", 1'b1, flags.always_on_flag)
    `CHK("int enabled", 1'b0, flags.interrupt_enabled_flag)
    wb(4'h0, 1'b0);
    `CHK("flags reg low", 3'h2, d[2:0])
    $display("reset test done");
    for (int i = 0; i < 2; i++) begin
      i_prt.pulse(0);
      @(posedge clk);
      `CHK("first scan", 1'(i == 0), flags.first_scan_flag)
      `CHK("alternate", 1'(i == 0), flags.alternate_scan_flag)
    end
    i_prt.set_mode(ssf_pkg::SSF_SW_RUN, ssf_pkg::SSF_CPU_RUN);
    i_prt.pulse(0);
    @(posedge clk);
    `CHK("first after run", 1'b1, flags.first_scan_flag)
    $display("scan test done");
    for (int s = 0; s < 3; s++) begin
      for (int c = 0; c < 4; c++) begin
        i_prt.set_mode(ssf_pkg::ssf_switch_t'(s), ssf_pkg::ssf_cpu_t'(c));
        repeat (2) @(posedge clk);
        xm = {s == 1 && c == 1, s == 2 && c == 1, c == 2, c == 3, s == 2 && c == 0, s == 0};
        gm = {flags.switch_run_flag, flags.terminal_run_flag, flags.test_run_flag,
              flags.test_stop_flag, flags.terminal_program_flag, flags.switch_stop_flag};
        `CHK("mode", xm, gm)
        wb(4'h4, 1'b0);
        `CHK("mode reg", 32'(c * 4 + s), d)
      end
    end
    $display("mode test done");
    i_prt.pulse(1);
    @(posedge clk);
    `CHK("stop instr", 1'b1, flags.instruction_stop_flag)
    i_prt.pulse(2);
    @(posedge clk);
    `CHK("int on", 1'b1, flags.interrupt_enabled_flag)
    i_prt.pulse(3);
    @(posedge clk);
    `CHK("int off", 1'b0, flags.interrupt_enabled_flag)
    wb(4'h4, 1'b1);
    wb(4'h0, 1'b1);
    wb(4'h4, 1'b0);
    `CHK("mode after write", 32'h0000_000e, d)
    `CHK("off after write", 1'b0, flags.always_off_flag)
    wb(4'h8, 1'b0);
    `CHK("unmapped err", 1'b1, e)
    // Run entry in the same cycle as a scan boundary must still mark that scan.
    i_prt.set_mode(ssf_pkg::SSF_SW_RUN, ssf_pkg::SSF_CPU_PROGRAM);
    i_prt.pulse(0);
    fork
      i_prt.set_mode(ssf_pkg::SSF_SW_RUN, ssf_pkg::SSF_CPU_RUN);
      i_prt.pulse(0);
    join
    @(posedge clk);
    `CHK("first on run edge", 1'b1, flags.first_scan_flag)
    $display("event and bus test done");
    half(`SSF_B_TWENT, `SSF_HALF_TWENT_MS * MS);
    half(`SSF_B_TENTH, `SSF_HALF_TENTH_MS * MS);
    half(`SSF_B_SEC, `SSF_HALF_SECOND_MS * MS);
    `CHK("minute high", 1'b1, flags.minute_square_wave)
    $display("wave test done");
    conclude();
  end
endmodule
